// ### hdl/ddcn_core.sv
// Dual-channel down-converter: swap selector, oscillator and mixer,
// integrate-and-dump decimator, gain, quarter-rate real output.
// Assumes converter samples and the align pin are synchronous to core_clk.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module ddcn_core
    import ddcn_pkg::*;
(
    input  wire logic                    core_clk,               // Sampling clock
    input  wire logic                    sys_rst,                // Sync reset, high
    input  wire logic [ADDR_W-1:0]       reg_addr,               // Register address
    input  wire logic [DATA_W-1:0]       reg_wdata,              // Write data
    input  wire logic                    reg_wr,                 // Write strobe
    input  wire logic                    reg_rd,                 // Read strobe
    output logic [DATA_W-1:0]            reg_rdata,              // Read data, next cycle
    input  wire logic                    adc_valid,              // Sample strobe
    input  wire logic signed [ADC_W-1:0] adc_a,                  // Channel A sample
    input  wire logic signed [ADC_W-1:0] adc_b,                  // Channel B sample
    input  wire logic                    powerdown_or_align_pin, // Align pulse input
    output logic                         out_valid,              // Output strobe
    output logic                         out_real,               // Output is real
    output ddcn_smp_t                    out_a,                  // Channel A output
    output ddcn_smp_t                    out_b                   // Channel B output
);

    // Clamp of the programmed ratio into 2..32
    function automatic logic [LOG_W-1:0] dec_log_eff(input logic [LOG_W-1:0] v);
        if (v < LOG_MIN) begin
            return LOG_MIN;
        end else if (v > LOG_MAX) begin
            return LOG_MAX;
        end
        return v;
    endfunction

    // Compensation gain with saturation: 6 dB doubling, 3 dB near root two
    function automatic logic signed [SMP_W-1:0] gain_apply(input logic signed [SMP_W-1:0] x,
                                                          input logic real_g);
        logic signed [SMP_W+1:0] e;
        logic signed [SMP_W+1:0] y;
        e = (SMP_W+2)'(x);
        if (real_g) begin
            y = e + (e >>> 2) + (e >>> 3) + (e >>> 5);
        end else begin
            y = e <<< 1;
        end
        if (y > $signed((SMP_W+2)'({1'b0, {(SMP_W-1){1'b1}}}))) begin
            return {1'b0, {(SMP_W-1){1'b1}}};
        end else if (y < -$signed((SMP_W+2)'({1'b0, {(SMP_W-1){1'b1}}})) - 1) begin
            return {1'b1, {(SMP_W-1){1'b0}}};
        end
        return y[SMP_W-1:0];
    endfunction

    // Register state
    ddcn_ctrl_t        ctrl_reg, ctrl_next;       // Control word
    logic [NCO_W-1:0]  freq_reg, freq_next;       // Pending frequency
    logic [NCO_W-1:0]  act_reg, act_next;         // Active frequency
    logic              pend_reg, pend_next;       // Frequency waiting for restart
    logic              rst_prev_reg;              // Last seen restart bit
    logic              pin_reg;                   // Previous align pin level
    logic [DATA_W-1:0] rdata_reg, rdata_next;     // Read data
    logic              align;                     // Restart or align event

    // Oscillator and stage A
    logic [NCO_W-1:0]        phase_reg, phase_next; // Phase accumulator
    logic signed [ADC_W-1:0] samp_reg [NCH];        // Raw samples, stage A
    logic                    sv_reg;                // Stage A sample valid
    logic signed [LUT_W-1:0] cos_w;                 // Cosine for stage A
    logic signed [LUT_W-1:0] sin_w;                 // Sine for stage A
    logic                    run_mix;               // Mixer in use

    // Divider and output control
    logic [CNT_W-1:0]  cnt_reg, cnt_next;         // Decimation counter
    logic [LOG_W-1:0]  dlog;                      // Effective log2 ratio
    logic              last;                      // Dump this sample
    logic              dump;                      // Decimated output now
    logic              fs4_pend_reg, fs4_pend_next; // Second real sample due
    logic              fs4_sgn_reg, fs4_sgn_next;   // Quarter-rate sign
    logic              valid_reg, valid_next;     // Output strobe
    logic              real_reg, real_next;       // Output real flag
    ddcn_smp_t         smp_reg [NCH];             // Output samples

    assign run_mix = ctrl_reg.enable & ~ctrl_reg.real_mode;
    assign dlog    = dec_log_eff(ctrl_reg.dec_log);
    assign last    = (cnt_reg == CNT_W'((1 << dlog) - 1));
    assign dump    = sv_reg & ctrl_reg.enable & last & ~align;
    // Restart bit toggle, or enabled pin pulse taken on the clock edge
    assign align   = (ctrl_reg.restart != rst_prev_reg) |
                     (ctrl_reg.sync_en & powerdown_or_align_pin & ~pin_reg);

    // Register writes, pending and active frequency, read mux
    always_comb begin
        ctrl_next  = ctrl_reg;
        freq_next  = freq_reg;
        act_next   = act_reg;
        pend_next  = pend_reg;
        rdata_next = '0;
        if (align) begin
            act_next  = freq_reg;
            pend_next = 1'b0;
        end
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    ctrl_next = ddcn_ctrl_t'(reg_wdata[CTRL_W-1:0]);
                end
                REG_FREQ: begin
                    freq_next = reg_wdata;
                    pend_next = 1'b1;                                   // Set wins
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:   rdata_next = DATA_W'(ctrl_reg);
                REG_FREQ:   rdata_next = freq_reg;
                REG_ACTIVE: rdata_next = act_reg;
                REG_STATUS: rdata_next = DATA_W'({cnt_reg, ctrl_reg.enable, pend_reg});
                default:    rdata_next = '0;                            // Unmapped reads zero
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_reg     <= ddcn_ctrl_t'(CTRL_RST);
            freq_reg     <= '0;
            act_reg      <= '0;
            pend_reg     <= 1'b0;
            rst_prev_reg <= 1'b0;
            pin_reg      <= 1'b0;
            rdata_reg    <= '0;
        end else begin
            ctrl_reg     <= ctrl_next;
            freq_reg     <= freq_next;
            act_reg      <= act_next;
            pend_reg     <= pend_next;
            rst_prev_reg <= ctrl_reg.restart;
            pin_reg      <= powerdown_or_align_pin;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // Phase accumulator, signed word wraps modulo 2^32
    always_comb begin
        phase_next = phase_reg;
        if (align) begin
            phase_next = '0;
        end else if (adc_valid & run_mix) begin
            phase_next = phase_reg + act_reg;
        end
    end

    // Oscillator and stage A sample flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_reg   <= '0;
            sv_reg      <= 1'b0;
            samp_reg[0] <= '0;
            samp_reg[1] <= '0;
        end else begin
            phase_reg <= phase_next;
            sv_reg    <= adc_valid;
            if (adc_valid) begin
                samp_reg[0] <= adc_a;
                samp_reg[1] <= adc_b;
            end
        end
    end

    // Sine and cosine of the current phase, aligned with stage A
    ddcn_sin_rom u_rom (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .rd_en    (adc_valid & run_mix),
        .phase    (phase_reg[NCO_W-1 -: PH_W]),
        .cos_out  (cos_w),
        .sin_out  (sin_w)
    );

    // Shared divider, strobe and quarter-rate sequencing
    always_comb begin
        cnt_next      = cnt_reg;
        fs4_pend_next = 1'b0;
        fs4_sgn_next  = fs4_sgn_reg;
        valid_next    = 1'b0;
        real_next     = real_reg;
        if (align) begin
            cnt_next     = '0;
            fs4_sgn_next = 1'b0;
        end else if (sv_reg & ctrl_reg.enable) begin
            cnt_next = last ? '0 : cnt_reg + CNT_W'(1);
        end
        if (~ctrl_reg.enable & sv_reg) begin
            valid_next = 1'b1;
            real_next  = 1'b1;
        end else if (dump) begin
            valid_next = 1'b1;
            real_next  = ctrl_reg.real_mode | ctrl_reg.fs4;
            if (ctrl_reg.fs4 & ~ctrl_reg.real_mode) begin
                fs4_pend_next = 1'b1;
                fs4_sgn_next  = ~fs4_sgn_reg;
            end
        end else if (fs4_pend_reg & ~align) begin
            valid_next = 1'b1;
        end
    end

    // Shared control flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_reg      <= '0;
            fs4_pend_reg <= 1'b0;
            fs4_sgn_reg  <= 1'b0;
            valid_reg    <= 1'b0;
            real_reg     <= 1'b1;
        end else begin
            cnt_reg      <= cnt_next;
            fs4_pend_reg <= fs4_pend_next;
            fs4_sgn_reg  <= fs4_sgn_next;
            valid_reg    <= valid_next;
            real_reg     <= real_next;
        end
    end

    // Per-channel mixer, accumulators and output registers
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        logic signed [ADC_W-1:0]  x;                   // Filter input after swap
        logic signed [PROD_W-1:0] prod_i;              // Sample times cosine
        logic signed [PROD_W-1:0] prod_q;              // Sample times sine
        logic signed [SMP_W-1:0]  mix_i;               // Mixed in-phase
        logic signed [SMP_W-1:0]  mix_q;               // Mixed quadrature
        logic signed [ACC_W-1:0]  sum_i;               // Running sum with sample
        logic signed [ACC_W-1:0]  sum_q;               // Running sum with sample
        logic signed [ACC_W-1:0]  acc_i_reg, acc_i_next; // In-phase accumulator
        logic signed [ACC_W-1:0]  acc_q_reg, acc_q_next; // Quadrature accumulator
        logic signed [SMP_W-1:0]  avg_i;               // Decimated in-phase
        logic signed [SMP_W-1:0]  avg_q;               // Decimated quadrature
        logic signed [SMP_W-1:0]  hold_q_reg, hold_q_next; // Second real sample
        ddcn_smp_t                smp_next;            // Next output

        // Mixer: real sample times e^(+jwn), quadrature negated on inversion
        always_comb begin
            x      = ctrl_reg.swap ? samp_reg[NCH-1-ch] : samp_reg[ch];
            prod_i = PROD_W'(x) * PROD_W'(cos_w);
            prod_q = PROD_W'(x) * PROD_W'(sin_w);
            if (ctrl_reg.real_mode) begin
                mix_i = SMP_W'(x) <<< 1;
                mix_q = '0;
            end else if (ctrl_reg.invert) begin
                mix_i = prod_i[PROD_W-1 -: SMP_W];
                mix_q = -prod_q[PROD_W-1 -: SMP_W];
            end else begin
                mix_i = prod_i[PROD_W-1 -: SMP_W];
                mix_q = prod_q[PROD_W-1 -: SMP_W];
            end
        end

        // Integrate-and-dump low-pass decimator, boxcar of ratio length
        always_comb begin
            sum_i      = acc_i_reg + ACC_W'(mix_i);
            sum_q      = acc_q_reg + ACC_W'(mix_q);
            avg_i      = SMP_W'(sum_i >>> dlog);
            avg_q      = SMP_W'(sum_q >>> dlog);
            acc_i_next = acc_i_reg;
            acc_q_next = acc_q_reg;
            if (align) begin
                acc_i_next = '0;
                acc_q_next = '0;
            end else if (sv_reg & ctrl_reg.enable) begin
                acc_i_next = last ? '0 : sum_i;
                acc_q_next = last ? '0 : sum_q;
            end
            if (ctrl_reg.gain) begin
                avg_i = gain_apply(avg_i, ctrl_reg.real_mode);
                avg_q = gain_apply(avg_q, ctrl_reg.real_mode);
            end
        end

        // Output selection: bypass, complex pair, real sample, or quarter-rate stream
        always_comb begin
            smp_next    = smp_reg[ch];
            hold_q_next = hold_q_reg;
            if (~ctrl_reg.enable & sv_reg) begin
                smp_next.i = SMP_W'(samp_reg[ch]);
                smp_next.q = '0;
            end else if (dump) begin
                if (ctrl_reg.real_mode) begin
                    smp_next.i = avg_i;
                    smp_next.q = '0;
                end else if (ctrl_reg.fs4) begin
                    smp_next.i  = fs4_sgn_reg ? -avg_i : avg_i;
                    smp_next.q  = '0;
                    hold_q_next = fs4_sgn_reg ? avg_q : -avg_q;
                end else begin
                    smp_next.i = avg_i;
                    smp_next.q = avg_q;
                end
            end else if (fs4_pend_reg & ~align) begin
                smp_next.i = hold_q_reg;
                smp_next.q = '0;
            end
        end

        // Channel flops
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                acc_i_reg   <= '0;
                acc_q_reg   <= '0;
                hold_q_reg  <= '0;
                smp_reg[ch] <= '0;
            end else begin
                acc_i_reg   <= acc_i_next;
                acc_q_reg   <= acc_q_next;
                hold_q_reg  <= hold_q_next;
                smp_reg[ch] <= smp_next;
            end
        end
    end

    // Output drive
    assign out_valid = valid_reg;
    assign out_real  = real_reg;
    assign out_a     = smp_reg[0];
    assign out_b     = smp_reg[1];

endmodule

// ### hdl/ddcn_pkg.sv
// Constants, register map and carrier types of the down-converter block.
// Assumes one sampling-rate clock and a plain strobe-based register port.
//
// Operation
// - Complex decimation 2..32, 32-bit oscillator, mixer, filter
// - Whole path enabled by one control bit
// - Real mode bypasses mixer; zero word saves power
// - Channel swap selector ahead of the filters
// - Complex: shift, low-pass at 0 Hz, rate over ratio
// - Optional 6 dB gain in complex mode
// - Real mode: no shift, real half, rate over ratio
// - Optional 3 dB gain in real mode
// - Quarter-rate mix gives real samples, twice rate
// - Sample times complex exponential gives fin plus fnco
// - Oscillator word is signed two's complement frequency
// - New frequency active only after restart or align
// - Phase inversion option gives fin minus fnco
// - Filter passes most of band, rejects stop band
// - Real mode bandwidth is half the complex one
// - Align pin sampled on clock edge once enabled
// - Align resets dividers, phase, loads pending frequency

package ddcn_pkg;

    // Data path widths
    localparam int ADC_W   = 14;          // Converter sample width
    localparam int SMP_W   = 16;          // Output sample width
    localparam int NCO_W   = 32;          // Oscillator word width
    localparam int LUT_W   = 16;          // Sine table word width
    localparam int PH_W    = 6;           // Phase bits used for lookup
    localparam int IDX_W   = 4;           // Quarter-wave table index width
    localparam int ACC_W   = 21;          // Accumulator: 16 bits plus log2(32)
    localparam int CNT_W   = 5;           // Decimation counter width
    localparam int LOG_W   = 3;           // Width of log2 of the ratio
    localparam int NCH     = 2;           // Number of channels
    localparam int PROD_W  = ADC_W + LUT_W; // Mixer product width

    // Register port
    localparam int ADDR_W  = 8;           // Register address width
    localparam int DATA_W  = 32;          // Register data width

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00; // Control word
    localparam logic [ADDR_W-1:0] REG_FREQ   = 8'h04; // Pending oscillator word
    localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h08; // Active oscillator word
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c; // Status word

    // Ratio limits as log2
    localparam logic [LOG_W-1:0] LOG_MIN = 3'h1; // Ratio 2
    localparam logic [LOG_W-1:0] LOG_MAX = 3'h5; // Ratio 32

    // Control word, bit 0 is enable
    typedef struct packed {
        logic [LOG_W-1:0] dec_log;   // Bits 10:8, log2 of ratio
        logic             restart;   // Bit 7, toggle to restart mixer
        logic             sync_en;   // Bit 6, align pin enable
        logic             swap;      // Bit 5, cross channels
        logic             invert;    // Bit 4, mixer phase inversion
        logic             fs4;       // Bit 3, quarter-rate real output
        logic             gain;      // Bit 2, compensation gain
        logic             real_mode; // Bit 1, real decimation
        logic             enable;    // Bit 0, down-converter on
    } ddcn_ctrl_t;

    localparam int CTRL_W = $bits(ddcn_ctrl_t);             // Control width
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h100;      // Off, ratio 2

    // One output sample pair
    typedef struct packed {
        logic signed [SMP_W-1:0] i; // In-phase or real sample
        logic signed [SMP_W-1:0] q; // Quadrature sample, zero when real
    } ddcn_smp_t;

endpackage

// ### hdl/ddcn_sin_rom.sv
// Quarter-wave sine and cosine table with registered outputs.
// Assumes the phase is presented in the cycle its enable is high.
`timescale 1ns/1ps

module ddcn_sin_rom
    import ddcn_pkg::*;
(
    input  wire logic                    core_clk,  // Sampling clock
    input  wire logic                    sys_rst,   // Synchronous reset
    input  wire logic                    rd_en,     // Lookup enable
    input  wire logic [PH_W-1:0]         phase,     // Quadrant and index
    output logic signed [LUT_W-1:0]      cos_out,   // Registered cosine
    output logic signed [LUT_W-1:0]      sin_out    // Registered sine
);

    logic signed [LUT_W-1:0] cos_next;  // Cosine lookup
    logic signed [LUT_W-1:0] sin_next;  // Sine lookup

    // Signed quarter-wave lookup, folded by quadrant
    function automatic logic signed [LUT_W-1:0] wave(input logic [1:0] quad,
                                                     input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] k;
        logic signed [LUT_W-1:0] v;
        k = quad[0] ? ~idx : idx;
        case (k)
            4'h0: v = 16'h0648;
            4'h1: v = 16'h12c8;
            4'h2: v = 16'h1f1a;
            4'h3: v = 16'h2b1f;
            4'h4: v = 16'h36ba;
            4'h5: v = 16'h41ce;
            4'h6: v = 16'h4c40;
            4'h7: v = 16'h55f5;
            4'h8: v = 16'h5ed7;
            4'h9: v = 16'h66cf;
            4'ha: v = 16'h6dc9;
            4'hb: v = 16'h73b5;
            4'hc: v = 16'h7884;
            4'hd: v = 16'h7c29;
            4'he: v = 16'h7e9c;
            default: v = 16'h7fd8;
        endcase
        return quad[1] ? -v : v;
    endfunction

    // Cosine leads sine by one quadrant
    always_comb begin
        sin_next = wave(phase[PH_W-1 -: 2], phase[IDX_W-1:0]);
        cos_next = wave(phase[PH_W-1 -: 2] + 2'h1, phase[IDX_W-1:0]);
    end

    // Output registers, updated only on lookup
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cos_out <= '0;
            sin_out <= '0;
        end else if (rd_en) begin
            cos_out <= cos_next;
            sin_out <= sin_next;
        end
    end

endmodule

// ### dv/ddcn_core_assertions.sv
// Port checker for ddcn_core, bound after the module.
// Assumes adc_valid is low around control writes.
`timescale 1ns/1ps
module ddcn_core_assertions
    import ddcn_pkg::*;
(
    input wire logic                    core_clk,               // Clock
    input wire logic                    sys_rst,                // Reset
    input wire logic [ADDR_W-1:0]       reg_addr,               // Address
    input wire logic [DATA_W-1:0]       reg_wdata,              // Write data
    input wire logic                    reg_wr,                 // Write
    input wire logic                    reg_rd,                 // Read
    input wire logic [DATA_W-1:0]       reg_rdata,              // Read data
    input wire logic                    adc_valid,              // Strobe
    input wire logic signed [ADC_W-1:0] adc_a,                  // Sample A
    input wire logic signed [ADC_W-1:0] adc_b,                  // Sample B
    input wire logic                    powerdown_or_align_pin, // Align
    input wire logic                    out_valid,              // Out strobe
    input wire logic                    out_real,               // Real flag
    input wire ddcn_smp_t               out_a,                  // Out A
    input wire ddcn_smp_t               out_b                   // Out B
);
    logic [CTRL_W-1:0] ctl_reg; // Control mirror
    logic [6:0]        cnt_reg; // Samples since output
    logic [1:0]        av_reg;  // Strobe delay line
    logic              ok_reg;  // Interval undisturbed
    // Mirror control, count samples between outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) ctl_reg <= CTRL_RST;
        else if (reg_wr && reg_addr == REG_CTRL) ctl_reg <= reg_wdata[CTRL_W-1:0];
        av_reg <= {av_reg[0], adc_valid};
        cnt_reg <= out_valid ? 7'h0 : cnt_reg + av_reg[1];
        ok_reg <= (ok_reg | out_valid) & !reg_wr & !powerdown_or_align_pin & !sys_rst;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside slot");
    AST_BYPASS_A: assert property (!ctl_reg[0] && adc_valid |-> ##2 out_valid &&
        out_a == {SMP_W'($past(adc_a, 2)), 16'h0}) else $error("bypass A wrong");
    AST_BYPASS_B: assert property (!ctl_reg[0] && adc_valid |-> ##2
        out_b == {SMP_W'($past(adc_b, 2)), 16'h0}) else $error("bypass B wrong");
    AST_REAL_FLAG: assert property (out_valid && ctl_reg == $past(ctl_reg, 3) |->
        out_real == (!ctl_reg[0] || ctl_reg[1] || ctl_reg[3])) else $error("real flag");
    AST_REAL_Q: assert property (ctl_reg[3:0] == 4'h3 && out_valid |->
        out_a.q == 0 && out_b.q == 0) else $error("real q not zero");
    AST_RATE: assert property (ok_reg && out_valid && ctl_reg[0] && !ctl_reg[3] |->
        cnt_reg + av_reg[1] == 7'h1 << ctl_reg[10:8]) else $error("rate wrong");
    AST_FS4_PAIR: assert property (ctl_reg[3:0] == 4'h9 && $rose(out_valid) |=> out_valid)
        else $error("fs4 pair missing");
    AST_NO_SPUR: assert property (!$past(adc_valid) && !$past(adc_valid, 2) &&
        !$past(adc_valid, 3) |-> !out_valid) else $error("spurious output");
endmodule
bind ddcn_core ddcn_core_assertions u_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .adc_valid, .adc_a, .adc_b, .powerdown_or_align_pin,
    .out_valid, .out_real, .out_a, .out_b);

// ### dv/ddcn_host_model.sv
// Host side: counts output strobes, keeps last pair, drives align.
// Assumes one-cycle align requests from the bench.
`timescale 1ns/1ps
module ddcn_host_model
    import ddcn_pkg::*;
(
    input  wire logic      core_clk,  // Clock
    input  wire logic      sys_rst,   // Reset
    input  wire logic      out_valid, // Output strobe
    input  wire ddcn_smp_t out_a,     // Output A
    input  wire logic      align_req, // Pulse request
    output logic           align_pin, // Align pulse
    output ddcn_smp_t      last_a,    // Last pair taken
    output logic [15:0]    seen       // Strobes counted
);
    // Pulse changes only just after the rising edge
    always_ff @(posedge core_clk) begin
        align_pin <= align_req && !sys_rst;
        seen <= sys_rst ? 16'h0 : seen + out_valid;
        if (out_valid) last_a <= out_a;
    end
endmodule

// ### dv/tb_top.sv
// Bench: registers, align, all modes and ratios, fixed values.
// Assumes ddcn_core and the host model at 250 MHz.
`timescale 1ns/1ps
module tb_top;
    import ddcn_pkg::*;
    logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, adc_valid = 0, req = 0, rs = 0;
    logic pin, out_valid, out_real; // Pin and flags
    logic [ADDR_W-1:0] reg_addr = '0; // Address
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, d; // Bus data
    logic signed [ADC_W-1:0] adc_a = '0, adc_b = '0; // Samples
    logic signed [15:0] s0, qn; // Saved outputs
    logic [15:0] seen, n0; // Strobe counts
    logic [31:0] seed = 32'hc959; // Random state
    ddcn_smp_t out_a, out_b, last_a; // Output pairs
    int mismatches = 0, check_count = 0; // Counters
    always #2 core_clk = ~core_clk;
    ddcn_core u_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .adc_valid, .adc_a, .adc_b, .powerdown_or_align_pin(pin), .out_valid, .out_real,
        .out_a, .out_b);
    ddcn_host_model u_host (.core_clk, .sys_rst, .out_valid, .out_a, .align_req(req),
        .align_pin(pin), .last_a, .seen);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Control write; toggling restart aligns phase each time
    task automatic cfg(input logic [10:0] c);
        rs = !rs;
        wr(REG_CTRL, {21'h0, c[10:8], rs, c[6:0]});
        repeat (4) @(posedge core_clk);
    endtask
    // Stream n samples, constant x or random when x is zero
    task automatic strm(input int n, input logic [13:0] x);
        repeat (n) begin
            @(posedge core_clk);
            seed = lfsr(seed);
            adc_valid <= 1'b1;
            adc_a <= (x != 0) ? x : seed[13:0];
            adc_b <= (x != 0) ? ~x : seed[27:14];
        end
        @(posedge core_clk);
        adc_valid <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    initial begin
        #200000 mismatches++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(REG_CTRL);
        chk(d, 32'h100);
        rd(8'h10);
        chk(d, 32'h0);
        wr(REG_FREQ, 32'hc0000000); // Minus a quarter rate
        wr(REG_ACTIVE, 32'h1);
        rd(REG_ACTIVE);
        chk(d, 32'h0);
        cfg(11'h141);
        rd(REG_ACTIVE);
        chk(d, 32'hc0000000);
        wr(REG_FREQ, 32'h40000000);
        @(posedge core_clk) req <= 1'b1;
        @(posedge core_clk) req <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(REG_ACTIVE);
        chk(d, 32'h40000000);
        cfg(11'h100);
        n0 = seen;
        strm(20, 0);
        chk(seen - n0, 20);
        $display("registers and bypass done");
        for (int m = 0; m < 3; m++) begin
            for (int l = 1; l <= 5; l++) begin
                cfg({l[2:0], 8'h01} | (m == 1 ? 11'h2 : m == 2 ? 11'h8 : 11'h0));
                n0 = seen;
                strm(64, 0);
                chk(seen - n0, (m == 2 ? 128 : 64) >> l);
                $display("mode %0d ratio %0d done", m, l);
            end
        end
        for (int k = 0; k < 3; k++) begin
            cfg(k == 0 ? 11'h103 : k == 1 ? 11'h107 : 11'h123);
            strm(2, 14'h100);
            chk({16'h0, last_a.i}, k == 0 ? 32'h200 : k == 1 ? 32'h2d0 : 32'hfdfe);
        end
        cfg(11'h101);
        strm(2, 14'h100);
        {s0, qn} = last_a;
        cfg(11'h105);
        strm(2, 14'h100);
        chk({16'h0, last_a.i}, {16'h0, s0 <<< 1});
        cfg(11'h111);
        strm(2, 14'h100);
        chk(32'(last_a.q + qn inside {[-1:1]}), 32'h1);
        $display("fixed values done");
        complete_run();
    end
endmodule
